//--- common/erxf_map.svh
// Offsets, field positions, reset values and counts of the receive filter.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
// What this block does
// - Six criteria: station, pattern, wake-up, hash, group and all-ones address.
// - One eight-bit control register holds every enable and the combine mode.
// - One combine-select bit picks AND or OR merging of enabled verdicts.
// - AND mode: frame rejected unless every enabled criterion accepts it.
// - OR mode: frame accepted if any enabled criterion accepts it.
// - Control register zero: accept every frame, no address or CRC test.
// - CRC check enable set drops frames with bad check sequence after filtering.
// - Pattern enable: AND drops failing frames, OR accepts passing ones.
// - Station criterion met only on exact six-byte destination match.
// - Group criterion met when bit 0 of first destination byte is set.
// - All-ones criterion met only for an all-ones destination address.
// - Hash criterion: CRC of destination indexes table bit, passes if set.
`ifndef ERXF_MAP_SVH
`define ERXF_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ERXF_OFS_CTRL 12'h000
`define ERXF_OFS_ADDR_LO 12'h004
`define ERXF_OFS_ADDR_HI 12'h008
`define ERXF_OFS_HASH_LO 12'h00c
`define ERXF_OFS_HASH_HI 12'h010
`define ERXF_OFS_STATUS 12'h014
`define ERXF_OFS_COUNT 12'h018

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define ERXF_CTRL_RESET 8'ha1
`define ERXF_BIT_STATION 7
`define ERXF_BIT_COMBINE 6
`define ERXF_BIT_CRC 5
`define ERXF_BIT_PATTERN 4
`define ERXF_BIT_WAKEUP 3
`define ERXF_BIT_HASH 2
`define ERXF_BIT_GROUP 1
`define ERXF_BIT_ALLONES 0
`define ERXF_CRIT_MASK 8'h9f

// ----------------------------------------
// Address and hash constants
// ----------------------------------------
`define ERXF_ADDR_BYTES 6
`define ERXF_ADDR_LAST 3'h5
`define ERXF_CRC_INIT 32'hffffffff
`define ERXF_CRC_POLY 32'hedb88320
`define ERXF_HASH_HI 28
`define ERXF_HASH_LO 23

`endif

//--- common/erxf_pkg.sv
// Types shared by the receive filter modules.
// Assumes nothing of its surroundings.
package erxf_pkg;

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_HEAD, RX_BODY} erxf_rx_state_t;

  typedef logic [7:0] erxf_ctrl_t;

endpackage

//--- verilog/erxf_addr_match.sv
// Destination address capture and the address-only criteria.
// Assumes the caller strobes each of the first six frame bytes with its index.
`timescale 1ns/10ps
`include "erxf_map.svh"
module erxf_addr_match import erxf_pkg::*; #(
  parameter int NBYTES = `ERXF_ADDR_BYTES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Byte capture
  input wire logic cap_en,
  input wire logic [2:0] cap_idx,
  input wire logic [7:0] cap_byte,
  // Programmed local address, first byte in the low bits
  input wire logic [8*NBYTES-1:0] station_addr,
  // Criteria
  output logic station_hit,
  output logic group_hit,
  output logic all_ones_hit
);

  wire [8*NBYTES-1:0] dest;

  genvar g;
  generate
    for (g = 0; g < NBYTES; g++) begin : g_byte
      logic [7:0] byte_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          byte_r <= 8'h00;
        end else if (cap_en && cap_idx == 3'(g)) begin
          byte_r <= cap_byte;
        end
      end
      assign dest[8*g +: 8] = byte_r;
    end
  endgenerate

  assign station_hit = (dest == station_addr);
  assign group_hit = dest[0];
  assign all_ones_hit = &dest;

endmodule // erxf_addr_match

//--- verilog/erxf_hash_crc.sv
// Running CRC over the destination bytes and the hash table index taken from it.
// Assumes start marks the first byte of a frame together with byte_en.
`timescale 1ns/10ps
`include "erxf_map.svh"
module erxf_hash_crc import erxf_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Byte stream
  input wire logic start,
  input wire logic byte_en,
  input wire logic [7:0] byte_in,
  // Table index
  output logic [5:0] hash_idx
);

  logic [31:0] crc_r;
  logic [31:0] crc_seed;

  function automatic logic [31:0] erxf_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `ERXF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Seeding on the first byte lets frames follow back to back with no gap.
  assign crc_seed = start ? `ERXF_CRC_INIT : crc_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_r <= `ERXF_CRC_INIT;
    end else if (byte_en) begin
      crc_r <= erxf_crc_byte(crc_seed, byte_in);
    end
  end

  assign hash_idx = crc_r[`ERXF_HASH_HI:`ERXF_HASH_LO];

endmodule // erxf_hash_crc

//--- verilog/erxf_top.sv
// Receive filter: APB register slave, frame tracking and the accept verdict.
// Assumes a byte stream from the MAC receive path and pattern, wake-up and
// check-sequence verdicts that are valid on the last byte of each frame.
`timescale 1ns/10ps
`include "erxf_map.svh"
module erxf_top import erxf_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sof,
  input wire logic rx_eof,
  // Verdicts of the outer engines, valid with the last byte
  input wire logic rx_fcs_ok,
  input wire logic pattern_match_ok,
  input wire logic wakeup_match_ok,
  // Verdict
  output logic verdict_valid,
  output logic verdict_accept
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  erxf_rx_state_t st_r;
  erxf_rx_state_t st_nxt;
  erxf_ctrl_t ctrl_r;
  logic [47:0] station_addr_r;
  logic [63:0] hash_table_r;
  logic [2:0] byte_idx_r;
  logic [2:0] byte_idx_nxt;
  logic addr_full_r;
  logic addr_full_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic verdict_valid_r;
  logic verdict_accept_r;
  logic [15:0] acc_cnt_r;
  logic [15:0] rej_cnt_r;
  logic [6:0] sel;
  logic setup;
  logic wr;
  logic [31:0] rd_mux;
  logic start;
  logic cap_en;
  logic [2:0] cap_idx;
  logic frame_end;
  logic station_hit;
  logic group_hit;
  logic all_ones_hit;
  logic [5:0] hash_idx;
  logic hash_hit;
  logic [7:0] meet;
  logic [7:0] en;
  logic and_pass;
  logic or_pass;
  logic filt_pass;
  logic crc_pass;
  logic promisc;
  logic accept_nxt;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic logic [6:0] erxf_decode(input logic [11:0] a);
    case (a)
      `ERXF_OFS_CTRL: erxf_decode = 7'h01;
      `ERXF_OFS_ADDR_LO: erxf_decode = 7'h02;
      `ERXF_OFS_ADDR_HI: erxf_decode = 7'h04;
      `ERXF_OFS_HASH_LO: erxf_decode = 7'h08;
      `ERXF_OFS_HASH_HI: erxf_decode = 7'h10;
      `ERXF_OFS_STATUS: erxf_decode = 7'h20;
      `ERXF_OFS_COUNT: erxf_decode = 7'h40;
      default: erxf_decode = 7'h00;
    endcase
  endfunction

  assign sel = erxf_decode(paddr);
  assign setup = psel && !penable;
  // A write lands only at the access edge that also sees pready high.
  assign wr = psel && penable && pready_r && pwrite;

  assign rd_mux = ({32{sel[0]}} & {24'h000000, ctrl_r})
                | ({32{sel[1]}} & station_addr_r[31:0])
                | ({32{sel[2]}} & {16'h0000, station_addr_r[47:32]})
                | ({32{sel[3]}} & hash_table_r[31:0])
                | ({32{sel[4]}} & hash_table_r[63:32])
                | ({32{sel[5]}} & {28'h0000000, addr_full_r, st_r != RX_IDLE, verdict_valid_r,
                                    verdict_accept_r})
                | ({32{sel[6]}} & {rej_cnt_r, acc_cnt_r});

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Read data is latched in the setup cycle so the access phase needs no wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && (sel == 7'h00);
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `ERXF_CTRL_RESET;
      station_addr_r <= 48'h000000000000;
      hash_table_r <= 64'h0000000000000000;
    end else if (wr) begin
      if (sel[0]) begin
        ctrl_r <= pwdata[7:0];
      end
      if (sel[1]) begin
        station_addr_r[31:0] <= pwdata;
      end
      if (sel[2]) begin
        station_addr_r[47:32] <= pwdata[15:0];
      end
      if (sel[3]) begin
        hash_table_r[31:0] <= pwdata;
      end
      if (sel[4]) begin
        hash_table_r[63:32] <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  // A start of frame always restarts capture, even inside a running frame.
  assign start = rx_valid && rx_sof;
  assign cap_en = start || (rx_valid && st_r == RX_HEAD);
  assign cap_idx = start ? 3'h0 : byte_idx_r;
  assign frame_end = rx_valid && rx_eof && (start || st_r != RX_IDLE);

  always_comb begin
    st_nxt = st_r;
    byte_idx_nxt = byte_idx_r;
    addr_full_nxt = addr_full_r;
    case (st_r)
      RX_IDLE: begin
        if (start) begin
          st_nxt = RX_HEAD;
          byte_idx_nxt = 3'h1;
          addr_full_nxt = 1'b0;
        end
      end
      RX_HEAD: begin
        if (start) begin
          byte_idx_nxt = 3'h1;
          addr_full_nxt = 1'b0;
        end else if (rx_valid) begin
          byte_idx_nxt = byte_idx_r + 3'h1;
          if (byte_idx_r == `ERXF_ADDR_LAST) begin
            st_nxt = RX_BODY;
            addr_full_nxt = 1'b1;
          end
        end
      end
      RX_BODY: begin
        if (start) begin
          st_nxt = RX_HEAD;
          byte_idx_nxt = 3'h1;
          addr_full_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = RX_IDLE;
      end
    endcase
    if (frame_end) begin
      st_nxt = RX_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= RX_IDLE;
      byte_idx_r <= 3'h0;
      addr_full_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      byte_idx_r <= byte_idx_nxt;
      addr_full_r <= addr_full_nxt;
    end
  end

  erxf_addr_match u_addr (
    .pclk(pclk),
    .presetn(presetn),
    .cap_en(cap_en),
    .cap_idx(cap_idx),
    .cap_byte(rx_data),
    .station_addr(station_addr_r),
    .station_hit(station_hit),
    .group_hit(group_hit),
    .all_ones_hit(all_ones_hit)
  );

  erxf_hash_crc u_hash (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .byte_en(cap_en),
    .byte_in(rx_data),
    .hash_idx(hash_idx)
  );

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  // Address criteria fail on frames of two to six bytes, as addr_full_r is set only after the sixth byte; a one-byte frame sees the previous frame's addr_full_r.
  assign hash_hit = hash_table_r[hash_idx];
  assign meet[`ERXF_BIT_STATION] = addr_full_r && station_hit;
  assign meet[`ERXF_BIT_COMBINE] = 1'b0;
  assign meet[`ERXF_BIT_CRC] = 1'b0;
  assign meet[`ERXF_BIT_PATTERN] = pattern_match_ok;
  assign meet[`ERXF_BIT_WAKEUP] = wakeup_match_ok && addr_full_r && station_hit;
  assign meet[`ERXF_BIT_HASH] = addr_full_r && hash_hit;
  assign meet[`ERXF_BIT_GROUP] = addr_full_r && group_hit;
  assign meet[`ERXF_BIT_ALLONES] = addr_full_r && all_ones_hit;

  assign en = ctrl_r & `ERXF_CRIT_MASK;
  assign and_pass = &(~en | meet);
  assign or_pass = (en == 8'h00) || |(en & meet);
  assign filt_pass = ctrl_r[`ERXF_BIT_COMBINE] ? and_pass : or_pass;
  assign crc_pass = !ctrl_r[`ERXF_BIT_CRC] || rx_fcs_ok;
  assign promisc = (ctrl_r == 8'h00);
  assign accept_nxt = promisc || (filt_pass && crc_pass);

  // The verdict follows the last byte by one edge, before any buffer commit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verdict_valid_r <= 1'b0;
      verdict_accept_r <= 1'b0;
    end else begin
      verdict_valid_r <= frame_end;
      if (frame_end) begin
        verdict_accept_r <= accept_nxt;
      end
    end
  end

  // A counter bump in the clearing cycle is kept, not lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_cnt_r <= 16'h0000;
      rej_cnt_r <= 16'h0000;
    end else begin
      if (wr && sel[6]) begin
        acc_cnt_r <= {15'h0000, frame_end && accept_nxt};
        rej_cnt_r <= {15'h0000, frame_end && !accept_nxt};
      end else if (frame_end) begin
        if (accept_nxt) begin
          acc_cnt_r <= acc_cnt_r + 16'h0001;
        end else begin
          rej_cnt_r <= rej_cnt_r + 16'h0001;
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign verdict_valid = verdict_valid_r;
  assign verdict_accept = verdict_accept_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_promisc_accept: assert property (
    frame_end && ctrl_r == 8'h00 |=> verdict_valid && verdict_accept)
    else $error("promiscuous frame not accepted");

  chk_and_allones: assert property (
    frame_end && ctrl_r[6] && ctrl_r[0] && !(addr_full_r && all_ones_hit) |=> !verdict_accept)
    else $error("AND mode passed a non all-ones frame");

  chk_or_group: assert property (
    frame_end && !ctrl_r[6] && ctrl_r[1] && !ctrl_r[5] && addr_full_r && group_hit |=> verdict_accept)
    else $error("OR mode dropped a group frame");

  chk_crc_drop: assert property (
    frame_end && ctrl_r != 8'h00 && ctrl_r[5] && !rx_fcs_ok |=> !verdict_accept)
    else $error("bad check sequence frame accepted");

  chk_crc_ignore: assert property (
    frame_end && !ctrl_r[5] |=> verdict_accept == $past(promisc || filt_pass))
    else $error("check sequence swayed the verdict");

  chk_station_and: assert property (
    frame_end && ctrl_r[6] && ctrl_r[7] && !(addr_full_r && station_hit) |=> !verdict_accept)
    else $error("foreign destination passed in AND mode");

  chk_pattern_and: assert property (
    frame_end && ctrl_r[6] && ctrl_r[4] && !pattern_match_ok |=> !verdict_accept)
    else $error("failing pattern passed in AND mode");

  chk_wakeup_or: assert property (
    frame_end && !ctrl_r[6] && ctrl_r[3] && !ctrl_r[5] && wakeup_match_ok && addr_full_r && station_hit
    |=> verdict_accept)
    else $error("wake-up frame for own station dropped");

  chk_hash_only: assert property (
    frame_end && ctrl_r == 8'h04 |=> verdict_accept == $past(addr_full_r && hash_hit))
    else $error("hash verdict mismatch");

  chk_verdict_time: assert property (
    rx_valid && rx_eof && (rx_sof || st_r != RX_IDLE) |=> verdict_valid ##1 !verdict_valid || $past(rx_eof))
    else $error("verdict not one edge after frame end");

  chk_ctrl_write: assert property (
    wr && paddr == `ERXF_OFS_CTRL |=> ctrl_r == $past(pwdata[7:0]))
    else $error("control write lost");

endmodule // erxf_top

//--- bench/erxf_rx_source.sv
// Partner model of the MAC receive path: frame bytes and engine verdicts.
// Assumes send is called from a bench process that is synchronous to pclk.
`timescale 1ns/10ps
module erxf_rx_source (
  // Clock
  input wire logic pclk,
  // Byte stream and engine verdicts
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_fcs_ok,
  output logic pattern_match_ok,
  output logic wakeup_match_ok
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    {rx_fcs_ok, pattern_match_ok, wakeup_match_ok} = 3'h0;
  end

  // Verdict lines show the inverse of their final value away from the
  // last byte, so early sampling in the design is caught.
  task automatic send(input logic [47:0] dest, input int len, input logic [2:0] flg);
    int i;
    for (i = 0; i < len; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= (i < 6) ? dest[8*i +: 8] : 8'(i);
      rx_sof <= (i == 0);
      rx_eof <= (i == len - 1);
      {rx_fcs_ok, pattern_match_ok, wakeup_match_ok} <= (i == len - 1) ? flg : ~flg;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~rx_data;
    {rx_fcs_ok, pattern_match_ok, wakeup_match_ok} <= ~flg;
  endtask
endmodule // erxf_rx_source

//--- bench/erxf_top_tb.sv
// Self-checking bench of the receive filter.
// Assumes the APB slave answers with pready and the verdict follows eof.
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module erxf_top_tb;
  // ----------------------------------------
  // Signals and constants
  // ----------------------------------------
  localparam logic [47:0] STA = 48'h5544_3322_1100;
  localparam logic [47:0] OTH = 48'h0a09_0807_0604;
  localparam logic [47:0] ONES = 48'hffff_ffff_ffff;
  localparam logic [63:0] HT = 64'h0f0f_f0f0_3c3c_a5a5;
  typedef struct packed {logic [7:0] ctl; logic [47:0] dst; logic [2:0] flg; logic [3:0] len;} erxf_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic rx_valid, rx_sof, rx_eof, rx_fcs_ok, pattern_match_ok, wakeup_match_ok;
  logic [7:0] rx_data;
  logic verdict_valid, verdict_accept, ex;
  int miscompares = 0;
  int checks_done = 0;
  int n_acc = 0;
  int n_rej = 0;
  erxf_row_t rows[26];

  erxf_top erxf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_fcs_ok(rx_fcs_ok),
    .pattern_match_ok(pattern_match_ok), .wakeup_match_ok(wakeup_match_ok),
    .verdict_valid(verdict_valid), .verdict_accept(verdict_accept));
  erxf_rx_source erxf_rx_source_inst (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_fcs_ok(rx_fcs_ok), .pattern_match_ok(pattern_match_ok),
    .wakeup_match_ok(wakeup_match_ok));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Reference verdict and bus tasks
  // ----------------------------------------
  function automatic logic expect_acc(erxf_row_t r);
    logic [31:0] c;
    logic [5:0] m, en;
    logic ok;
    c = 32'hffff_ffff;
    for (int i = 0; i < 48; i++) c = (c[0] ^ r.dst[i]) ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
    m = {r.dst == STA, r.flg[1], r.flg[0] && r.dst == STA, HT[c[28:23]], r.dst[0], &r.dst};
    if (r.len < 7) m = m & 6'h10;
    en = {r.ctl[7], r.ctl[4:0]};
    if (r.ctl == 8'h00) return 1'b1;
    ok = (en == 6'h00) ? 1'b1 : r.ctl[6] ? &(m | ~en) : |(m & en);
    return ok && !(r.ctl[5] && !r.flg[2]);
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t no bus answer", $time);
      wrap_up;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_verdict;
    int n;
    n = 0;
    #1;
    while (verdict_valid !== 1'b1 && n < 4) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (verdict_valid !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t no verdict", $time);
      wrap_up;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{8'h00, OTH, 3'h0, 8}, '{8'h80, STA, 3'h4, 8}, '{8'h80, STA ^ 48'h0100_0000_0000, 3'h4, 8},
      '{8'hc0, STA, 3'h4, 8}, '{8'hc0, OTH, 3'h6, 8}, '{8'h10, OTH, 3'h6, 8}, '{8'h10, OTH, 3'h4, 8},
      '{8'h50, STA, 3'h5, 8}, '{8'h08, STA, 3'h5, 8}, '{8'h08, OTH, 3'h5, 8}, '{8'h04, OTH, 3'h4, 8},
      '{8'h04, 48'h1234_5678_9abc, 3'h4, 8}, '{8'hc4, 48'h0000_0000_7701, 3'h4, 8},
      '{8'h02, OTH | 48'h1, 3'h4, 7}, '{8'h02, OTH, 3'h4, 6}, '{8'h01, ONES, 3'h4, 8},
      '{8'h01, ONES ^ 48'h8000_0000_0000, 3'h4, 8}, '{8'h21, ONES, 3'h0, 8}, '{8'h20, OTH, 3'h0, 8},
      '{8'h20, OTH, 3'h4, 8}, '{8'hd3, ONES, 3'h6, 8}, '{8'h93, OTH, 3'h4, 8}, '{8'h01, ONES, 3'h4, 3},
      '{8'h9f, OTH, 3'h6, 9}, '{8'h41, OTH, 3'h4, 8}, '{8'h01, ONES, 3'h4, 6}};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    `CHK({prdata, pready, pslverr, verdict_valid, verdict_accept}, 36'h0)
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0000_00a1)
    apb(1'b1, 12'h004, STA[31:0]);
    apb(1'b1, 12'h008, {16'h0, STA[47:32]});
    apb(1'b1, 12'h00c, HT[31:0]);
    apb(1'b1, 12'h010, HT[63:32]);
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, {24'h0, rows[i].ctl});
      apb(1'b0, 12'h000, 32'h0);
      `CHK(rd[7:0], rows[i].ctl)
      ex = expect_acc(rows[i]);
      erxf_rx_source_inst.send(rows[i].dst, rows[i].len, rows[i].flg);
      wait_verdict;
      `CHK(verdict_accept, ex)
      if (ex) n_acc++;
      else n_rej++;
    end
    // Counters and status are bookkeeping around the verdict path.
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd, {16'(n_rej), 16'(n_acc)})
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, 12'h020, 32'hffff_ffff);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h014, 32'h0);
    st = rd;
    apb(1'b1, 12'h014, ~st);
    apb(1'b0, 12'h014, 32'h0);
    `CHK(rd, st)
    // A reset in mid-run must restore the control value and clear the counters.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({prdata, pready, pslverr, verdict_valid, verdict_accept}, 36'h0)
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0000_00a1)
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd, 32'h0)
    wrap_up;
  end
endmodule // erxf_top_tb
